/* File: inc/eipc_consts.vh */
// Overview of operation
// R1: Ext 2/3 edge chosen by polarity bits
// R2: Ext 4-6 rising; sources 5, 6 inverted
// R3: Ext 2 from four pulse flags, manual clear
// R4: Ext 3 busy fall, ext 4 status change
// R5: Ext 5 from EEPROM done or SPI
// R6: Ext 6 from transfer, ticks, temperature
// R7: Ext 0/1 from mapped pins, auto clear
// R8: Enable gates interrupt; hardware sets flag
// R9: Secondary sources have own enable, flag
// R10: Primary flags clear on vectoring
// R11: Secondary flags clear only on zero write
// R12: Bit operations are byte read-modify-write
// R13: Software clears flags with ones-mask byte
// R14: Transfer, tick, temp bits at 0,1,2,4
// R15: Pulse and SPI bits at 6,5,7
// R16: Six priority groups pair sources
// R17: Two priority bits give four levels
// R18: Fixed polling order breaks ties
// R19: Core source vector addresses
// R20: Ext 2 to 6 vector addresses
// R21: Software sets priorities once at start
// R22: Only higher priority preempts; call next
// R23: Defer acknowledge on return or enable write
// R24: Reset clears flags, enables, priorities
// R25: Shared request from flag and enable
`ifndef EIPC_CONSTS_VH
`define EIPC_CONSTS_VH
`define EIPC_ADDR_TMRF 16'h0088
`define EIPC_ADDR_ENB0 16'h00a8
`define EIPC_ADDR_IPLO 16'h00a9
`define EIPC_ADDR_IEN2 16'h009a
`define EIPC_ADDR_ENB1 16'h00b8
`define EIPC_ADDR_IPHI 16'h00b9
`define EIPC_ADDR_T2CTL 16'h00c8
`define EIPC_ADDR_IRQF 16'h00c0
`define EIPC_ADDR_SECFA 16'h00e8
`define EIPC_ADDR_SECFB 16'h00f8
`define EIPC_ADDR_SECEA 16'h2700
`define EIPC_ADDR_SECEB 16'h2701
`define EIPC_RESET_BYTE 8'h00
`define EIPC_BIT_INT3_EDGE 6
`define EIPC_BIT_INT2_EDGE 5
`define EIPC_BIT_XFER 0
`define EIPC_BIT_SEC 1
`define EIPC_BIT_MIN 2
`define EIPC_BIT_TEMP 4
`define EIPC_BIT_YPUL 5
`define EIPC_BIT_XPUL 6
`define EIPC_BIT_EEX 7
`define EIPC_BIT_VPUL 5
`define EIPC_BIT_WPUL 6
`define EIPC_BIT_SPI 7
`define EIPC_BIT_PLLUP 0
`define EIPC_BIT_PLLDN 1
`define EIPC_VEC_EXT0 16'h0003
`define EIPC_VEC_TMR0 16'h000b
`define EIPC_VEC_EXT1 16'h0013
`define EIPC_VEC_TMR1 16'h001b
`define EIPC_VEC_SER0 16'h0023
`define EIPC_VEC_SER1 16'h0083
`define EIPC_VEC_EXT2 16'h004b
`define EIPC_VEC_EXT3 16'h0053
`define EIPC_VEC_EXT4 16'h005b
`define EIPC_VEC_EXT5 16'h0063
`define EIPC_VEC_EXT6 16'h006b
`define EIPC_NSRC 11
`endif

/* File: hdl/eipc_edge_detect.v */
`timescale 1ns/10ps
// Two-stage synchroniser plus edge detector; rise/fall chosen per use
module eipc_edge_detect (
  // System
  input wire clk_sys,
  input wire rst,
  // Signal
  input wire sigIn,
  input wire riseSel,
  // Result
  output wire edgePulse
);
  reg syncA_reg;
  reg syncB_reg;
  reg last_reg;
  always @(posedge clk_sys) begin
    if (rst) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      syncA_reg <= sigIn;
      syncB_reg <= syncA_reg;
      last_reg <= syncB_reg;
    end
  end
  assign edgePulse = riseSel ? (syncB_reg & ~last_reg) : (~syncB_reg & last_reg);
endmodule

/* File: hdl/eipc_secondary_flag.v */
`timescale 1ns/10ps
`include "eipc_consts.vh"
// Secondary flag: set by event, cleared only by a zero written to it
module eipc_secondary_flag (
  // System
  input wire clk_sys,
  input wire rst,
  // Control
  input wire setEvt,
  input wire wrStb,
  input wire wrBit,
  // State
  output reg flag_reg
);
  always @(posedge clk_sys) begin
    if (rst) begin
      flag_reg <= 1'b0; // R24
    end else if (setEvt) begin
      flag_reg <= 1'b1; // R8
    end else if (wrStb && !wrBit) begin
      flag_reg <= 1'b0; // R11 R12
    end
  end
endmodule

/* File: hdl/eipc_irq_ctrl.v */
`timescale 1ns/10ps
`include "eipc_consts.vh"
module eipc_irq_ctrl (
  // System
  input wire clk_sys,
  input wire rst,
  // Register port from the core
  input wire [15:0] regAddr,
  input wire regWr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata_reg,
  // Core instruction status
  input wire instrBoundary,
  input wire rtnExec,
  input wire serviceDone,
  // Core internal sources
  input wire timer0Ovf,
  input wire timer1Ovf,
  input wire serial0Req,
  input wire serial1Req,
  // Peripheral sources
  input wire dio0In,
  input wire dio1In,
  input wire xPulse,
  input wire yPulse,
  input wire wPulse,
  input wire vPulse,
  input wire ceBusy,
  input wire [2:0] voltage_status,
  input wire eepromBusy,
  input wire spiEvent,
  input wire transfer_busy,
  input wire clock_second_tick,
  input wire clock_minute_tick,
  input wire rtcTempEvent,
  input wire pll_up_event,
  input wire pll_down_event,
  // Vector call to core
  output reg callReq_reg,
  output reg [15:0] callVector_reg,
  output reg timer0Ack_reg,
  output reg timer1Ack_reg,
  output reg pllIrq_reg
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CALL = 1'b1;

  // Register state
  reg [7:0] enb0_reg;
  reg [7:0] enb1_reg;
  reg [7:0] ien2_reg;
  reg [7:0] prioLo_reg;
  reg [7:0] prioHi_reg;
  reg [7:0] t2ctl_reg;
  reg [7:0] tmrf_reg;
  reg [7:0] secEnA_reg;
  reg [7:0] secEnB_reg;
  reg [6:0] extFlag_reg;
  reg state_reg;
  reg [3:0] activeLvl_reg;
  reg [1:0] stackLvl_reg [0:3];
  reg [2:0] depth_reg;
  reg [2:0] voltSync0_reg;
  reg [2:0] voltSync1_reg;
  reg [2:0] voltLast_reg;

  // Write strobes
  wire wrTmrf = regWr && (regAddr == `EIPC_ADDR_TMRF);
  wire wrEnb0 = regWr && (regAddr == `EIPC_ADDR_ENB0);
  wire wrEnb1 = regWr && (regAddr == `EIPC_ADDR_ENB1);
  wire wrIen2 = regWr && (regAddr == `EIPC_ADDR_IEN2);
  wire wrPlo = regWr && (regAddr == `EIPC_ADDR_IPLO);
  wire wrPhi = regWr && (regAddr == `EIPC_ADDR_IPHI);
  wire wrT2 = regWr && (regAddr == `EIPC_ADDR_T2CTL);
  wire wrIrqf = regWr && (regAddr == `EIPC_ADDR_IRQF);
  wire wrSfa = regWr && (regAddr == `EIPC_ADDR_SECFA);
  wire wrSfb = regWr && (regAddr == `EIPC_ADDR_SECFB);
  wire wrSea = regWr && (regAddr == `EIPC_ADDR_SECEA);
  wire wrSeb = regWr && (regAddr == `EIPC_ADDR_SECEB);

  // Edge events from pins and peripherals
  wire e0Fall, e1Fall, xEv, yEv, wEv, vEv, busyEv, eexEv, spiEv;
  wire xferEv, secEv, minEv, tempEv, pllUpEv, pllDnEv;
  wire int2Rise = t2ctl_reg[`EIPC_BIT_INT2_EDGE];
  wire int3Rise = t2ctl_reg[`EIPC_BIT_INT3_EDGE];
  // Ext0/1 pins are falling edge; level mode handled below
  eipc_edge_detect uE0 (.clk_sys(clk_sys), .rst(rst), .sigIn(dio0In), .riseSel(1'b0),
    .edgePulse(e0Fall)); // R7
  eipc_edge_detect uE1 (.clk_sys(clk_sys), .rst(rst), .sigIn(dio1In), .riseSel(1'b0),
    .edgePulse(e1Fall)); // R7
  eipc_edge_detect uX (.clk_sys(clk_sys), .rst(rst), .sigIn(xPulse), .riseSel(int2Rise),
    .edgePulse(xEv)); // R1 R3
  eipc_edge_detect uY (.clk_sys(clk_sys), .rst(rst), .sigIn(yPulse), .riseSel(int2Rise),
    .edgePulse(yEv)); // R1 R3
  eipc_edge_detect uW (.clk_sys(clk_sys), .rst(rst), .sigIn(wPulse), .riseSel(int2Rise),
    .edgePulse(wEv)); // R1 R3
  eipc_edge_detect uV (.clk_sys(clk_sys), .rst(rst), .sigIn(vPulse), .riseSel(int2Rise),
    .edgePulse(vEv)); // R1 R3
  eipc_edge_detect uB (.clk_sys(clk_sys), .rst(rst), .sigIn(ceBusy), .riseSel(int3Rise),
    .edgePulse(busyEv)); // R1 R4
  // Inverted sources on 5 and 6 seen rising, i.e. source falling
  eipc_edge_detect uEe (.clk_sys(clk_sys), .rst(rst), .sigIn(~eepromBusy), .riseSel(1'b1),
    .edgePulse(eexEv)); // R2 R5
  eipc_edge_detect uSp (.clk_sys(clk_sys), .rst(rst), .sigIn(spiEvent), .riseSel(1'b1),
    .edgePulse(spiEv)); // R5
  eipc_edge_detect uXf (.clk_sys(clk_sys), .rst(rst), .sigIn(~transfer_busy), .riseSel(1'b1),
    .edgePulse(xferEv)); // R2 R6
  eipc_edge_detect uS (.clk_sys(clk_sys), .rst(rst), .sigIn(clock_second_tick),
    .riseSel(1'b1), .edgePulse(secEv)); // R6
  eipc_edge_detect uM (.clk_sys(clk_sys), .rst(rst), .sigIn(clock_minute_tick),
    .riseSel(1'b1), .edgePulse(minEv)); // R6
  eipc_edge_detect uT (.clk_sys(clk_sys), .rst(rst), .sigIn(rtcTempEvent), .riseSel(1'b1),
    .edgePulse(tempEv)); // R6
  eipc_edge_detect uPu (.clk_sys(clk_sys), .rst(rst), .sigIn(pll_up_event), .riseSel(1'b1),
    .edgePulse(pllUpEv)); // R9
  eipc_edge_detect uPd (.clk_sys(clk_sys), .rst(rst), .sigIn(pll_down_event),
    .riseSel(1'b1), .edgePulse(pllDnEv)); // R9

  // Ext0/1 level-mode samples, synchronised
  reg [1:0] lvlSync0_reg;
  reg [1:0] lvlSync1_reg;
  always @(posedge clk_sys) begin
    if (rst) begin
      lvlSync0_reg <= 2'b11;
      lvlSync1_reg <= 2'b11;
    end else begin
      lvlSync0_reg <= {dio1In, dio0In};
      lvlSync1_reg <= lvlSync0_reg;
    end
  end

  // Voltage status change detect
  always @(posedge clk_sys) begin
    if (rst) begin
      voltSync0_reg <= 3'h0;
      voltSync1_reg <= 3'h0;
      voltLast_reg <= 3'h0;
    end else begin
      voltSync0_reg <= voltage_status;
      voltSync1_reg <= voltSync0_reg;
      voltLast_reg <= voltSync1_reg;
    end
  end
  wire voltEv = (voltSync1_reg != voltLast_reg); // R4

  // Secondary flags; software byte writes with ones leave bits alone
  wire fXfer, fSec, fMin, fTemp, fY, fX, fEex, fV, fW, fSpi, fPu, fPd;
  eipc_secondary_flag uFXf (.clk_sys(clk_sys), .rst(rst), .setEvt(xferEv), .wrStb(wrSfa),
    .wrBit(regWdata[`EIPC_BIT_XFER]), .flag_reg(fXfer)); // R14
  eipc_secondary_flag uFS (.clk_sys(clk_sys), .rst(rst), .setEvt(secEv), .wrStb(wrSfa),
    .wrBit(regWdata[`EIPC_BIT_SEC]), .flag_reg(fSec)); // R14
  eipc_secondary_flag uFM (.clk_sys(clk_sys), .rst(rst), .setEvt(minEv), .wrStb(wrSfa),
    .wrBit(regWdata[`EIPC_BIT_MIN]), .flag_reg(fMin)); // R14
  eipc_secondary_flag uFT (.clk_sys(clk_sys), .rst(rst), .setEvt(tempEv), .wrStb(wrSfa),
    .wrBit(regWdata[`EIPC_BIT_TEMP]), .flag_reg(fTemp)); // R14
  eipc_secondary_flag uFY (.clk_sys(clk_sys), .rst(rst), .setEvt(yEv), .wrStb(wrSfa),
    .wrBit(regWdata[`EIPC_BIT_YPUL]), .flag_reg(fY)); // R15
  eipc_secondary_flag uFX (.clk_sys(clk_sys), .rst(rst), .setEvt(xEv), .wrStb(wrSfa),
    .wrBit(regWdata[`EIPC_BIT_XPUL]), .flag_reg(fX)); // R15
  eipc_secondary_flag uFE (.clk_sys(clk_sys), .rst(rst), .setEvt(eexEv), .wrStb(wrSfa),
    .wrBit(regWdata[`EIPC_BIT_EEX]), .flag_reg(fEex)); // R5
  eipc_secondary_flag uFV (.clk_sys(clk_sys), .rst(rst), .setEvt(vEv), .wrStb(wrSfb),
    .wrBit(regWdata[`EIPC_BIT_VPUL]), .flag_reg(fV)); // R15
  eipc_secondary_flag uFW (.clk_sys(clk_sys), .rst(rst), .setEvt(wEv), .wrStb(wrSfb),
    .wrBit(regWdata[`EIPC_BIT_WPUL]), .flag_reg(fW)); // R15
  eipc_secondary_flag uFSp (.clk_sys(clk_sys), .rst(rst), .setEvt(spiEv), .wrStb(wrSfb),
    .wrBit(regWdata[`EIPC_BIT_SPI]), .flag_reg(fSpi)); // R15
  eipc_secondary_flag uFPu (.clk_sys(clk_sys), .rst(rst), .setEvt(pllUpEv), .wrStb(wrSfb),
    .wrBit(regWdata[`EIPC_BIT_PLLUP]), .flag_reg(fPu)); // R9
  eipc_secondary_flag uFPd (.clk_sys(clk_sys), .rst(rst), .setEvt(pllDnEv), .wrStb(wrSfb),
    .wrBit(regWdata[`EIPC_BIT_PLLDN]), .flag_reg(fPd)); // R9

  wire [7:0] secFlagA = {fEex, fX, fY, fTemp, 1'b0, fMin, fSec, fXfer};
  wire [7:0] secFlagB = {fSpi, fW, fV, 3'b000, fPd, fPu};

  // Shared request lines: flag and individual enable together
  wire req2 = |(secFlagA[6:5] & secEnA_reg[6:5]) | |(secFlagB[6:5] & secEnB_reg[6:5]); // R25
  wire req5 = (fEex & secEnA_reg[`EIPC_BIT_EEX]) | (fSpi & secEnB_reg[`EIPC_BIT_SPI]); // R25
  wire req6 = |(secFlagA[4:0] & secEnA_reg[4:0]); // R25
  reg req2Last_reg;
  reg req5Last_reg;
  reg req6Last_reg;

  // Sources in polling order: ext0 ser1 t0 ext2 ext1 ext3 t1 ext4 ser0 ext5 ext6
  wire [10:0] srcReq = {extFlag_reg[6], extFlag_reg[5], serial0Req, extFlag_reg[4],
    tmrf_reg[7], extFlag_reg[3], tmrf_reg[3], extFlag_reg[2], tmrf_reg[5], serial1Req,
    tmrf_reg[1]}; // R18
  wire [10:0] srcEn = {enb1_reg[5], enb1_reg[4], enb0_reg[4], enb1_reg[3], enb0_reg[3],
    enb1_reg[2], enb0_reg[2], enb1_reg[1], enb0_reg[1], ien2_reg[0], enb0_reg[0]}; // R8
  // Group of each polled source
  function [2:0] grpOf;
    input [3:0] idx;
    begin
      grpOf = idx[3:1]; // R16
      if (idx == 4'd10) grpOf = 3'd5;
    end
  endfunction
  function [15:0] vecOf;
    input [3:0] idx;
    begin
      case (idx)
        4'd0: vecOf = `EIPC_VEC_EXT0; // R19
        4'd1: vecOf = `EIPC_VEC_SER1;
        4'd2: vecOf = `EIPC_VEC_TMR0;
        4'd3: vecOf = `EIPC_VEC_EXT2; // R20
        4'd4: vecOf = `EIPC_VEC_EXT1;
        4'd5: vecOf = `EIPC_VEC_EXT3;
        4'd6: vecOf = `EIPC_VEC_TMR1;
        4'd7: vecOf = `EIPC_VEC_EXT4;
        4'd8: vecOf = `EIPC_VEC_SER0;
        4'd9: vecOf = `EIPC_VEC_EXT5;
        4'd10: vecOf = `EIPC_VEC_EXT6;
        default: vecOf = 16'h0000;
      endcase
    end
  endfunction

  // Arbitration: highest level wins, earlier poll position on ties
  reg [3:0] bestIdx;
  reg [1:0] bestLvl;
  reg bestValid;
  reg [2:0] g;
  reg [1:0] lvl;
  integer i;
  always @* begin
    bestIdx = 4'd0;
    bestLvl = 2'd0;
    bestValid = 1'b0;
    g = 3'd0;
    lvl = 2'd0;
    for (i = 0; i < `EIPC_NSRC; i = i + 1) begin
      g = grpOf(i[3:0]);
      lvl = {prioHi_reg[g], prioLo_reg[g]}; // R17
      if (srcReq[i] && srcEn[i] && enb0_reg[7] &&
          (!bestValid || lvl > bestLvl)) begin
        bestIdx = i[3:0]; // R18
        bestLvl = lvl;
        bestValid = 1'b1;
      end
    end
  end
  // Preempt only when above every level in service
  wire preemptOk = !activeLvl_reg[bestLvl] &&
    !(|(activeLvl_reg >> bestLvl)); // R22
  wire blockWr = wrEnb0 | wrEnb1 | wrIen2 | wrPlo | wrPhi;
  wire ackNow = (state_reg == ST_IDLE) && bestValid && preemptOk && instrBoundary &&
    !rtnExec && !blockWr; // R23

  // Highest active level, for return tracking
  wire [1:0] topLvl = activeLvl_reg[3] ? 2'd3 : activeLvl_reg[2] ? 2'd2 :
    activeLvl_reg[1] ? 2'd1 : 2'd0;

  always @(posedge clk_sys) begin
    if (rst) begin
      enb0_reg <= `EIPC_RESET_BYTE; // R24
      enb1_reg <= `EIPC_RESET_BYTE;
      ien2_reg <= `EIPC_RESET_BYTE;
      prioLo_reg <= `EIPC_RESET_BYTE;
      prioHi_reg <= `EIPC_RESET_BYTE;
      t2ctl_reg <= `EIPC_RESET_BYTE;
      tmrf_reg <= `EIPC_RESET_BYTE;
      secEnA_reg <= `EIPC_RESET_BYTE;
      secEnB_reg <= `EIPC_RESET_BYTE;
      extFlag_reg <= 7'h00;
      state_reg <= ST_IDLE;
      activeLvl_reg <= 4'h0;
      callReq_reg <= 1'b0;
      callVector_reg <= 16'h0000;
      timer0Ack_reg <= 1'b0;
      timer1Ack_reg <= 1'b0;
      pllIrq_reg <= 1'b0;
      req2Last_reg <= 1'b0;
      req5Last_reg <= 1'b0;
      req6Last_reg <= 1'b0;
    end else begin
      if (wrEnb0) enb0_reg <= regWdata;
      if (wrEnb1) enb1_reg <= regWdata & 8'h3e;
      if (wrIen2) ien2_reg <= regWdata & 8'h01;
      if (wrPlo) prioLo_reg <= regWdata & 8'h3f;
      if (wrPhi) prioHi_reg <= regWdata & 8'h3f;
      if (wrT2) t2ctl_reg <= regWdata;
      if (wrSea) secEnA_reg <= regWdata;
      if (wrSeb) secEnB_reg <= regWdata;
      req2Last_reg <= req2;
      req5Last_reg <= req5;
      req6Last_reg <= req6;
      pllIrq_reg <= (fPu & secEnB_reg[`EIPC_BIT_PLLUP]) |
        (fPd & secEnB_reg[`EIPC_BIT_PLLDN]); // R9
      // Flag register: events set, vectoring clears; set beats clear
      begin : flagUpd
        reg [7:0] tNext;
        reg [6:0] xNext;
        tNext = tmrf_reg;
        xNext = extFlag_reg;
        if (wrTmrf) tNext = regWdata;
        if (wrIrqf) xNext = {regWdata[5:1], 2'b00} | 7'h00;
        if (ackNow) begin
          case (bestIdx)
            4'd0: tNext[1] = 1'b0; // R10
            4'd2: tNext[5] = 1'b0;
            4'd3: xNext[2] = 1'b0;
            4'd4: tNext[3] = 1'b0;
            4'd5: xNext[3] = 1'b0;
            4'd6: tNext[7] = 1'b0;
            4'd7: xNext[4] = 1'b0;
            4'd9: xNext[5] = 1'b0;
            4'd10: xNext[6] = 1'b0;
            default: xNext = xNext;
          endcase
        end
        if (tmrf_reg[0] ? e0Fall : !lvlSync1_reg[0]) tNext[1] = 1'b1; // R7
        if (tmrf_reg[2] ? e1Fall : !lvlSync1_reg[1]) tNext[3] = 1'b1; // R7
        if (timer0Ovf) tNext[5] = 1'b1;
        if (timer1Ovf) tNext[7] = 1'b1;
        if (req2 && !req2Last_reg) xNext[2] = 1'b1; // R3
        if (busyEv) xNext[3] = 1'b1; // R4
        if (voltEv) xNext[4] = 1'b1; // R4
        if (req5 && !req5Last_reg) xNext[5] = 1'b1; // R5
        if (req6 && !req6Last_reg) xNext[6] = 1'b1; // R6
        tmrf_reg <= tNext;
        extFlag_reg <= xNext;
      end
      timer0Ack_reg <= ackNow && (bestIdx == 4'd2);
      timer1Ack_reg <= ackNow && (bestIdx == 4'd6);
      case (state_reg)
        ST_IDLE: begin
          callReq_reg <= 1'b0;
          if (ackNow) begin
            callReq_reg <= 1'b1; // R22
            callVector_reg <= vecOf(bestIdx);
            activeLvl_reg[bestLvl] <= 1'b1;
            state_reg <= ST_CALL;
          end else if (serviceDone) begin
            activeLvl_reg[topLvl] <= 1'b0;
          end
        end
        ST_CALL: begin
          callReq_reg <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Read mux, registered
  always @(posedge clk_sys) begin
    if (rst) begin
      regRdata_reg <= 8'h00;
    end else begin
      case (regAddr)
        `EIPC_ADDR_TMRF: regRdata_reg <= tmrf_reg;
        `EIPC_ADDR_ENB0: regRdata_reg <= enb0_reg;
        `EIPC_ADDR_ENB1: regRdata_reg <= enb1_reg;
        `EIPC_ADDR_IEN2: regRdata_reg <= ien2_reg;
        `EIPC_ADDR_IPLO: regRdata_reg <= prioLo_reg;
        `EIPC_ADDR_IPHI: regRdata_reg <= prioHi_reg;
        `EIPC_ADDR_T2CTL: regRdata_reg <= t2ctl_reg & 8'h60;
        `EIPC_ADDR_IRQF: regRdata_reg <= {2'b00, extFlag_reg[6:2], 1'b0};
        `EIPC_ADDR_SECFA: regRdata_reg <= secFlagA;
        `EIPC_ADDR_SECFB: regRdata_reg <= secFlagB;
        `EIPC_ADDR_SECEA: regRdata_reg <= secEnA_reg;
        `EIPC_ADDR_SECEB: regRdata_reg <= secEnB_reg;
        default: regRdata_reg <= 8'h00;
      endcase
    end
  end
endmodule

/* File: verif/eipc_irq_ctrl_properties.sv */
`timescale 1ns/10ps
`include "eipc_consts.vh"
module eipc_irq_chk (
  // System
  input wire clk_sys,
  input wire rst,
  // Register port
  input wire [15:0] regAddr,
  input wire regWr,
  input wire [7:0] regRdata_reg,
  // Core status
  input wire instrBoundary,
  input wire rtnExec,
  // Call outputs
  input wire callReq_reg,
  input wire [15:0] callVector_reg,
  input wire timer0Ack_reg,
  input wire timer1Ack_reg,
  input wire pllIrq_reg
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_ctlWrite;
    regWr && (regAddr == `EIPC_ADDR_ENB0 || regAddr == `EIPC_ADDR_ENB1 ||
      regAddr == `EIPC_ADDR_IEN2 || regAddr == `EIPC_ADDR_IPLO || regAddr == `EIPC_ADDR_IPHI);
  endsequence
  sequence s_call;
    callReq_reg ##1 !callReq_reg;
  endsequence
  property p_callPulse;
    callReq_reg |-> s_call;
  endproperty
  a_callPulse: assert property (p_callPulse) else $error("call request longer than one cycle");
  property p_boundary;
    callReq_reg |-> $past(instrBoundary);
  endproperty
  a_boundary: assert property (p_boundary) else $error("call outside instruction boundary");
  property p_rtnDefer;
    not (rtnExec ##1 callReq_reg);
  endproperty
  a_rtnDefer: assert property (p_rtnDefer) else $error("call during return");
  property p_writeDefer;
    not (s_ctlWrite ##1 callReq_reg);
  endproperty
  a_writeDefer: assert property (p_writeDefer) else $error("call after control write");
  property p_vectorLegal;
    callReq_reg |=> callVector_reg inside {`EIPC_VEC_EXT0, `EIPC_VEC_TMR0, `EIPC_VEC_EXT1,
      `EIPC_VEC_TMR1, `EIPC_VEC_SER0, `EIPC_VEC_SER1, `EIPC_VEC_EXT2, `EIPC_VEC_EXT3,
      `EIPC_VEC_EXT4, `EIPC_VEC_EXT5, `EIPC_VEC_EXT6};
  endproperty
  a_vectorLegal: assert property (p_vectorLegal) else $error("illegal vector");
  property p_vectorHold;
    (!callReq_reg && !$past(callReq_reg) && !$past(callReq_reg, 2) && !$past(rst))
      |-> $stable(callVector_reg);
  endproperty
  a_vectorHold: assert property (p_vectorHold) else $error("vector changed without call");
  property p_t0Ack;
    timer0Ack_reg |-> callReq_reg ##1 callVector_reg == `EIPC_VEC_TMR0;
  endproperty
  a_t0Ack: assert property (p_t0Ack) else $error("timer 0 ack without its call");
  property p_t1Ack;
    timer1Ack_reg |-> callReq_reg ##1 callVector_reg == `EIPC_VEC_TMR1;
  endproperty
  a_t1Ack: assert property (p_t1Ack) else $error("timer 1 ack without its call");
  property p_resetQuiet;
    $past(rst) |-> !callReq_reg && !pllIrq_reg && regRdata_reg == 8'h00;
  endproperty
  a_resetQuiet: assert property (p_resetQuiet) else $error("output active after reset");
endmodule

/* File: verif/eipc_core_model.sv */
`timescale 1ns/10ps
module eipc_core_model (
  // System
  input wire clk_sys,
  input wire rst,
  // Bench control
  input wire stall,
  input wire retStart,
  // Core status
  output wire instrBoundary,
  output wire rtnExec,
  output wire serviceDone
);
  reg [1:0] retCnt_reg;
  // Boundary stays up during a return so deferral is really exercised
  assign instrBoundary = !stall;
  assign rtnExec = retCnt_reg != 2'h0;
  assign serviceDone = retCnt_reg == 2'h1;
  always @(posedge clk_sys) begin
    if (rst) begin
      retCnt_reg <= 2'h0;
    end else if (retStart) begin
      retCnt_reg <= 2'h2;
    end else if (retCnt_reg != 2'h0) begin
      retCnt_reg <= retCnt_reg - 2'h1;
    end
  end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`include "eipc_consts.vh"
module tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic regWr = 1'b0;
  logic [7:0] regWdata = 8'h00;
  logic stall = 1'b0;
  logic retStart = 1'b0;
  logic t0Ovf = 1'b0, t1Ovf = 1'b0, ser0 = 1'b0, ser1 = 1'b0;
  logic dio0 = 1'b1, dio1 = 1'b1, ceBusy = 1'b1;
  logic [2:0] volt = 3'h0;
  // Eeprom and transfer busy idle high, their fall is the event
  localparam logic [11:0] EV_IDLE = 12'h050;
  logic [11:0] ev = EV_IDLE;
  logic [7:0] regRdata, d;
  logic [15:0] callVector;
  logic instrBoundary, rtnExec, serviceDone, callReq, t0Ack, t1Ack, pllIrq;
  int err_count = 0;
  int tests_run = 0;
  int secBit [12] = '{6, 5, 6, 5, 7, 7, 0, 1, 2, 4, 0, 1};
  logic [11:0] secInB = 12'hc2c;
  logic [15:0] vecTab [11] = '{`EIPC_VEC_EXT0, `EIPC_VEC_SER1, `EIPC_VEC_TMR0, `EIPC_VEC_EXT2,
    `EIPC_VEC_EXT1, `EIPC_VEC_EXT3, `EIPC_VEC_TMR1, `EIPC_VEC_EXT4, `EIPC_VEC_SER0,
    `EIPC_VEC_EXT5, `EIPC_VEC_EXT6};
  logic [15:0] regTab [12] = '{`EIPC_ADDR_TMRF, `EIPC_ADDR_ENB0, `EIPC_ADDR_IPLO,
    `EIPC_ADDR_IEN2, `EIPC_ADDR_ENB1, `EIPC_ADDR_IPHI, `EIPC_ADDR_T2CTL, `EIPC_ADDR_IRQF,
    `EIPC_ADDR_SECFA, `EIPC_ADDR_SECFB, `EIPC_ADDR_SECEA, `EIPC_ADDR_SECEB};
  logic [15:0] setA [8] = '{`EIPC_ADDR_TMRF, `EIPC_ADDR_T2CTL, `EIPC_ADDR_ENB0, `EIPC_ADDR_ENB1,
    `EIPC_ADDR_IEN2, `EIPC_ADDR_SECEA, `EIPC_ADDR_SECEB, `EIPC_ADDR_IPLO};
  logic [7:0] setD [8] = '{8'h05, 8'h00, 8'h1f, 8'h3e, 8'h01, 8'h41, 8'h80, 8'h3f};

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  eipc_core_model u_core (.clk_sys(clk_sys), .rst(rst), .stall(stall), .retStart(retStart),
    .instrBoundary(instrBoundary), .rtnExec(rtnExec), .serviceDone(serviceDone));

  eipc_irq_ctrl u_dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWr(regWr),
    .regWdata(regWdata), .regRdata_reg(regRdata), .instrBoundary(instrBoundary),
    .rtnExec(rtnExec), .serviceDone(serviceDone), .timer0Ovf(t0Ovf), .timer1Ovf(t1Ovf),
    .serial0Req(ser0), .serial1Req(ser1), .dio0In(dio0), .dio1In(dio1), .xPulse(ev[0]),
    .yPulse(ev[1]), .wPulse(ev[2]), .vPulse(ev[3]), .ceBusy(ceBusy), .voltage_status(volt),
    .eepromBusy(ev[4]), .spiEvent(ev[5]), .transfer_busy(ev[6]), .clock_second_tick(ev[7]),
    .clock_minute_tick(ev[8]), .rtcTempEvent(ev[9]), .pll_up_event(ev[10]),
    .pll_down_event(ev[11]), .callReq_reg(callReq), .callVector_reg(callVector),
    .timer0Ack_reg(t0Ack), .timer1Ack_reg(t1Ack), .pllIrq_reg(pllIrq));

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    regAddr = a;
    regWdata = v;
    regWr = 1'b1;
    @(negedge clk_sys);
    regWr = 1'b0;
  endtask

  task automatic rc(input string name, input logic [15:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    regAddr = a;
    @(negedge clk_sys);
    check(name, {8'h00, regRdata}, {8'h00, exp});
  endtask

  task automatic waitCall(input logic [15:0] vec);
    int n;
    n = 0;
    while (callReq !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n == 60) begin
        err_count++;
        summarize();
      end
    end
    check("timerAck", {14'h0, t1Ack, t0Ack},
      {14'h0, vec == `EIPC_VEC_TMR1, vec == `EIPC_VEC_TMR0});
    @(negedge clk_sys);
    check("callVector", callVector, vec);
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      check("noCall", {15'h0, callReq}, 16'h0000);
    end
  endtask

  task automatic fire(input int i);
    @(negedge clk_sys);
    case (i)
      0: dio0 = 1'b0;
      1: ser1 = 1'b1;
      2: t0Ovf = 1'b1;
      3: ev[0] = 1'b1;
      4: dio1 = 1'b0;
      5: ceBusy = 1'b0;
      6: t1Ovf = 1'b1;
      7: volt = volt + 3'h1;
      8: ser0 = 1'b1;
      9: ev[5] = 1'b1;
      default: ev[6] = 1'b0;
    endcase
    @(negedge clk_sys);
    t0Ovf = 1'b0;
    t1Ovf = 1'b0;
    ev[0] = 1'b0;
  endtask

  // Return edges are all of the inactive polarity, so no new requests
  task automatic restore();
    dio0 = 1'b1;
    dio1 = 1'b1;
    ceBusy = 1'b1;
    ser0 = 1'b0;
    ser1 = 1'b0;
    ev = EV_IDLE;
  endtask

  task automatic retire();
    @(negedge clk_sys);
    retStart = 1'b1;
    @(negedge clk_sys);
    retStart = 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask

  initial begin
    logic [15:0] a;
    logic [7:0] m;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    foreach (regTab[i]) rc("resetValue", regTab[i], 8'h00);
    wr(16'h0042, 8'hff);
    rc("unmapped", 16'h0042, 8'h00);
    $display("Test reset done");
    for (int i = 0; i < 12; i++) begin
      a = secInB[i] ? `EIPC_ADDR_SECFB : `EIPC_ADDR_SECFA;
      m = 8'h01 << secBit[i];
      @(negedge clk_sys);
      ev[i] = ~ev[i];
      repeat (4) @(negedge clk_sys);
      ev[i] = ~ev[i];
      repeat (6) @(negedge clk_sys);
      rc("secFlagSet", a, m);
      wr(a, 8'hff);
      rc("secFlagKeep", a, m);
      wr(a, ~m);
      rc("secFlagClear", a, 8'h00);
    end
    $display("Test secondary flags done");
    foreach (setA[i]) wr(setA[i], setD[i]);
    foreach (setA[i]) rc("readBack", setA[i], setD[i]);
    wr(`EIPC_ADDR_IPLO, 8'h00);
    fire(2);
    quiet(10);
    rc("flagNoEnable", `EIPC_ADDR_TMRF, 8'h25);
    wr(`EIPC_ADDR_IRQF, 8'h02);
    rc("irqfWrite", `EIPC_ADDR_IRQF, 8'h02);
    wr(`EIPC_ADDR_IRQF, 8'h00);
    wr(`EIPC_ADDR_ENB0, 8'h9f);
    waitCall(`EIPC_VEC_TMR0);
    retire();
    rc("tmrfCleared", `EIPC_ADDR_TMRF, 8'h05);
    for (int i = 0; i < 11; i++) begin
      fire(i);
      waitCall(vecTab[i]);
      restore();
      retire();
    end
    rc("auxFlagsAuto", `EIPC_ADDR_IRQF, 8'h00);
    rc("tmrfAuto", `EIPC_ADDR_TMRF, 8'h05);
    rc("manualA", `EIPC_ADDR_SECFA, 8'h41);
    rc("manualB", `EIPC_ADDR_SECFB, 8'h80);
    wr(`EIPC_ADDR_SECFA, 8'hbe);
    wr(`EIPC_ADDR_SECFB, 8'h7f);
    $display("Test vectors done");
    for (int k = 0; k < 2; k++) begin
      stall = 1'b1;
      fire(0);
      fire(2);
      repeat (8) @(negedge clk_sys);
      stall = 1'b0;
      waitCall(k == 0 ? `EIPC_VEC_EXT0 : `EIPC_VEC_TMR0);
      restore();
      quiet(20);
      retire();
      waitCall(k == 0 ? `EIPC_VEC_TMR0 : `EIPC_VEC_EXT0);
      retire();
      wr(`EIPC_ADDR_IPHI, 8'h02);
    end
    $display("Test priority done");
    wr(`EIPC_ADDR_SECEB, 8'h81);
    @(negedge clk_sys);
    ev[10] = 1'b1;
    repeat (8) @(negedge clk_sys);
    check("pllIrqSet", {15'h0, pllIrq}, 16'h0001);
    ev[10] = 1'b0;
    wr(`EIPC_ADDR_SECFB, 8'hfe);
    @(negedge clk_sys);
    check("pllIrqClear", {15'h0, pllIrq}, 16'h0000);
    $display("Test pll done");
    summarize();
  end
endmodule

bind eipc_irq_ctrl eipc_irq_chk u_chk (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
  .regWr(regWr), .regRdata_reg(regRdata_reg), .instrBoundary(instrBoundary),
  .rtnExec(rtnExec), .callReq_reg(callReq_reg), .callVector_reg(callVector_reg),
  .timer0Ack_reg(timer0Ack_reg), .timer1Ack_reg(timer1Ack_reg), .pllIrq_reg(pllIrq_reg));
